/* common/msia_pkg.sv */
// ============================================================
// shared constants and carriers for the serial irq arbiter
package msia_pkg;

    // ============================================================
    // sizes
    localparam int NPORT = 16;
    localparam int NBRD = 16;
    localparam int NIRQ = 8;
    localparam int ITYPE_W = 3;

    // ============================================================
    // register map: arbitration result, read only
    localparam logic [15:0] ARB_RESULT_ADDR = 16'h0130;

    // ============================================================
    // system interrupt line select, one code per offered line
    typedef enum logic [2:0] {
        IRQ_LINE_3 = 3'h0,
        IRQ_LINE_5 = 3'h1,
        IRQ_LINE_9 = 3'h2,
        IRQ_LINE_10 = 3'h3,
        IRQ_LINE_11 = 3'h4,
        IRQ_LINE_12 = 3'h5,
        IRQ_LINE_14 = 3'h6,
        IRQ_LINE_15 = 3'h7
    } msia_irq_sel_t;

    // slot setup register written in the configuration cycle
    typedef struct packed {
        logic enable;
        msia_irq_sel_t sel;
    } msia_setup_t;

    localparam msia_setup_t SETUP_RESET = '{enable: 1'b0, sel: IRQ_LINE_3};

    // ============================================================
    // arbitration result word, 16 bits
    typedef struct packed {
        logic none;
        logic [3:0] rsvd;
        logic [ITYPE_W-1:0] itype;
        logic [3:0] board;
        logic [3:0] port;
    } msia_arb_t;

    localparam logic [15:0] ARB_NONE = 16'h8000;
    localparam logic [15:0] ARB_RESET = 16'h8000;

    // ============================================================
    // serial line levels
    localparam logic LVL_MARK = 1'b1;
    localparam logic LVL_SPACE = 1'b0;

endpackage

/* rtl/msia_prio_enc.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// fixed priority encoder: lowest set index wins
module msia_prio_enc (
    // request vector
    input wire logic [15:0] req,
    // result
    output logic any,
    output logic [3:0] idx
);

    // scan from the top so the lowest index overwrites last
    always_comb begin
        any = 1'b0;
        idx = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (req[i]) begin
                any = 1'b1;
                idx = 4'(i);
            end
        end
    end

endmodule // msia_prio_enc
`default_nettype wire

/* rtl/msia_arbiter.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Summary of operation
// - boards ranked fixed, board 0 highest
// - ports served fixed, port 0 first
// - eight selectable lines 3,5,9,10,11,12,14,15
// - at most one interrupt line ever driven
// - open collector: pull low when pending
// - winner board loads its top port info
// - one read gives board, port, type
// - up to sixteen boards arbitrate together
// - ports carry txd, rxd, dtr, dcd
// - logic 1 is mark, 0 is space
// - undriven receiver reads as mark
module msia_arbiter (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // board straps
    input wire logic [3:0] board_id_i,
    input wire logic idle_resp_i,
    // slot setup write from the control logic
    input wire logic setup_wr_i,
    input wire msia_pkg::msia_setup_t setup_data_i,
    // host i/o read of the arbitration register
    input wire logic io_rd_i,
    input wire logic [15:0] io_addr_i,
    output logic [15:0] io_data_o,
    output logic io_data_oe,
    // system interrupt lines, open collector
    output logic [7:0] irq_o,
    output logic [7:0] irq_oe,
    // board pending bus, one open collector line per board
    input wire logic [15:0] bpend_i,
    output logic [15:0] bpend_o,
    output logic [15:0] bpend_oe,
    // channel interrupt requests and types
    input wire logic [15:0] chan_irq_i,
    input wire logic [15:0][2:0] chan_itype_i,
    // serial lines, channel side
    input wire logic [15:0] chan_txd_i,
    input wire logic [15:0] chan_dtr_i,
    output logic [15:0] chan_rxd_o,
    output logic [15:0] chan_dcd_o,
    // serial lines, cable side
    output logic [15:0] txd_o,
    output logic [15:0] dtr_o,
    input wire logic [15:0] rxd_i,
    input wire logic [15:0] rx_open_i,
    input wire logic [15:0] dcd_i
);

    // ============================================================
    // straps: two pin flops, then caught once when both are filled
    logic [3:0] board_id_s1_q;
    logic [3:0] board_id_s2_q;
    logic idle_resp_s1_q;
    logic idle_resp_s2_q;
    logic [1:0] strap_wait_q;
    logic [3:0] board_id_q;
    logic idle_resp_q;
    logic strap_done_q;

    // strap pins are asynchronous like any other pin input
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            board_id_s1_q <= 4'h0;
            board_id_s2_q <= 4'h0;
            idle_resp_s1_q <= 1'b0;
            idle_resp_s2_q <= 1'b0;
            strap_wait_q <= 2'h0;
        end else begin
            board_id_s1_q <= board_id_i;
            board_id_s2_q <= board_id_s1_q;
            idle_resp_s1_q <= idle_resp_i;
            idle_resp_s2_q <= idle_resp_s1_q;
            strap_wait_q <= {strap_wait_q[0], 1'b1};
        end
    end

    // catch only once the second flop holds a real pin value,
    // otherwise the reset value of the chain would be taken
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            board_id_q <= 4'h0;
            idle_resp_q <= 1'b0;
            strap_done_q <= 1'b0;
        end else if (strap_wait_q[1] && !strap_done_q) begin
            board_id_q <= board_id_s2_q;
            idle_resp_q <= idle_resp_s2_q;
            strap_done_q <= 1'b1;
        end
    end

    // ============================================================
    // slot setup register
    msia_pkg::msia_setup_t setup_q;

    // only the setup cycle writes it; the line holds until the next setup write
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            setup_q <= msia_pkg::SETUP_RESET;
        end else if (setup_wr_i) begin
            setup_q <= setup_data_i;
        end
    end

    // ============================================================
    // pin synchronisers: host read strobe, address, pending bus
    logic rd_s1_q, rd_s2_q, rd_s3_q;
    logic [15:0] addr_s1_q, addr_s2_q;
    logic [15:0] bpend_s1_q, bpend_s2_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_s1_q <= 1'b0;
            rd_s2_q <= 1'b0;
            rd_s3_q <= 1'b0;
            addr_s1_q <= 16'h0000;
            addr_s2_q <= 16'h0000;
            bpend_s1_q <= 16'hFFFF;
            bpend_s2_q <= 16'hFFFF;
        end else begin
            rd_s1_q <= io_rd_i;
            rd_s2_q <= rd_s1_q;
            rd_s3_q <= rd_s2_q;
            addr_s1_q <= io_addr_i;
            addr_s2_q <= addr_s1_q;
            bpend_s1_q <= bpend_i;
            bpend_s2_q <= bpend_s1_q;
        end
    end

    // ============================================================
    // port arbitration inside this board
    logic port_any;
    logic [3:0] port_idx;

    msia_prio_enc u_port_prio (
        .req(chan_irq_i),
        .any(port_any),
        .idx(port_idx)
    );

    // ============================================================
    // board arbitration across the shared pending bus
    wire [15:0] bpend_seen = ~bpend_s2_q; // lines are active low
    logic brd_any;
    logic [3:0] brd_idx;

    msia_prio_enc u_board_prio (
        .req(bpend_seen),
        .any(brd_any),
        .idx(brd_idx)
    );

    // this board wins only if it is the lowest numbered pending one
    wire my_pend = port_any & setup_q.enable;
    wire i_win = my_pend & brd_any & (brd_idx == board_id_q);
    // with nothing pending anywhere, the strapped board answers idle
    wire i_idle = ~my_pend & ~brd_any & idle_resp_q;

    // ============================================================
    // arbitration register, reloaded every cycle outside a read
    msia_pkg::msia_arb_t arb_now;
    logic [15:0] arb_q;

    assign arb_now.none = 1'b0;
    assign arb_now.rsvd = 4'h0;
    assign arb_now.itype = chan_itype_i[port_idx];
    assign arb_now.board = board_id_q;
    assign arb_now.port = port_idx;

    wire [15:0] arb_d = i_win ? 16'(arb_now) : msia_pkg::ARB_NONE;

    // frozen while a read is in progress so the word cannot tear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            arb_q <= msia_pkg::ARB_RESET;
        end else if (!rd_s2_q) begin
            arb_q <= arb_d;
        end
    end

    // ============================================================
    // host read decode and data drive
    wire addr_hit = (addr_s2_q == msia_pkg::ARB_RESULT_ADDR);
    wire rd_start = rd_s2_q & ~rd_s3_q & addr_hit;
    logic [15:0] io_data_q;
    logic io_data_oe_q;
    logic resp_q;

    // decide once at the start of a read whether this board answers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            resp_q <= 1'b0;
        end else if (rd_start) begin
            resp_q <= i_win | i_idle;
        end else if (!rd_s2_q) begin
            resp_q <= 1'b0;
        end
    end

    // board, port and type leave together in one word
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            io_data_q <= msia_pkg::ARB_RESET;
            io_data_oe_q <= 1'b0;
        end else begin
            io_data_q <= arb_q;
            io_data_oe_q <= resp_q & rd_s2_q & addr_hit;
        end
    end

    assign io_data_o = io_data_q;
    assign io_data_oe = io_data_oe_q;

    // ============================================================
    // interrupt request and pending bus drive
    logic [7:0] irq_oe_q;
    logic [15:0] bpend_oe_q;

    // one-hot decode of the selected line; never more than one set
    wire [7:0] irq_onehot = 8'h01 << setup_q.sel;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_oe_q <= 8'h00;
            bpend_oe_q <= 16'h0000;
        end else begin
            irq_oe_q <= my_pend ? irq_onehot : 8'h00;
            bpend_oe_q <= my_pend ? (16'h0001 << board_id_q) : 16'h0000;
        end
    end

    // open collector: only ever drive a low, the pull-up gives high
    logic [7:0] irq_q;
    logic [15:0] bpend_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_q <= 8'h00;
            bpend_q <= 16'h0000;
        end else begin
            irq_q <= 8'h00;
            bpend_q <= 16'h0000;
        end
    end

    assign irq_o = irq_q;
    assign irq_oe = irq_oe_q;
    assign bpend_o = bpend_q;
    assign bpend_oe = bpend_oe_q;

    // ============================================================
    // per-port serial line stage
    logic [15:0] txd_q, dtr_q, rxd_q, dcd_q;

    for (genvar p = 0; p < msia_pkg::NPORT; p++) begin : g_port
        logic rxd_s1_q, rxd_s2_q;
        logic open_s1_q, open_s2_q;
        logic dcd_s1_q, dcd_s2_q;

        // cable inputs cross in through two flops each
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                rxd_s1_q <= msia_pkg::LVL_MARK;
                rxd_s2_q <= msia_pkg::LVL_MARK;
                open_s1_q <= 1'b1;
                open_s2_q <= 1'b1;
                dcd_s1_q <= 1'b0;
                dcd_s2_q <= 1'b0;
            end else begin
                rxd_s1_q <= rxd_i[p];
                rxd_s2_q <= rxd_s1_q;
                open_s1_q <= rx_open_i[p];
                open_s2_q <= open_s1_q;
                dcd_s1_q <= dcd_i[p];
                dcd_s2_q <= dcd_s1_q;
            end
        end

        // an open receiver looks like an idle line, not a break
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                rxd_q[p] <= msia_pkg::LVL_MARK;
                dcd_q[p] <= 1'b0;
                txd_q[p] <= msia_pkg::LVL_MARK;
                dtr_q[p] <= 1'b0;
            end else begin
                rxd_q[p] <= open_s2_q ? msia_pkg::LVL_MARK : rxd_s2_q;
                dcd_q[p] <= dcd_s2_q;
                txd_q[p] <= chan_txd_i[p];
                dtr_q[p] <= chan_dtr_i[p];
            end
        end
    end

    assign chan_rxd_o = rxd_q;
    assign chan_dcd_o = dcd_q;
    assign txd_o = txd_q;
    assign dtr_o = dtr_q;

endmodule // msia_arbiter
`default_nettype wire

/* bench/msia_arbiter_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// port checker for the arbiter
module msia_arbiter_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // host read
    input wire logic io_rd_i,
    input wire logic [15:0] io_addr_i,
    input wire logic [15:0] io_data_o,
    input wire logic io_data_oe,
    // interrupt side
    input wire logic [7:0] irq_o,
    input wire logic [7:0] irq_oe,
    input wire logic [15:0] bpend_i,
    input wire logic [15:0] bpend_oe,
    input wire logic [15:0] chan_irq_i,
    input wire logic [15:0][2:0] chan_itype_i,
    // receive side
    input wire logic [15:0] rx_open_i,
    input wire logic [15:0] chan_rxd_o
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // masks of everything ranked above the reported port and board
    wire logic [3:0] prt = io_data_o[3:0];
    wire logic [15:0] pmask = (16'h1 << prt) - 16'h1;
    wire logic [15:0] bmask = (16'h1 << io_data_o[7:4]) - 16'h1;
    sequence s_win;
        $rose(io_data_oe) && !io_data_o[15];
    endsequence
    a_one_line: assert property ($onehot0(irq_oe))
        else $error("more than one interrupt line driven");
    a_pull_low: assert property (|irq_oe |-> irq_o == 8'h00
        && $past(|chan_irq_i)) else $error("interrupt line misdriven");
    a_pend_pair: assert property ((|bpend_oe) == (|irq_oe)
        && $onehot0(bpend_oe)) else $error("board pending line wrong");
    a_idle_code: assert property (io_data_oe && io_data_o[15] |->
        io_data_o == msia_pkg::ARB_NONE) else $error("bad idle word");
    a_port_pick: assert property (s_win |-> chan_irq_i[prt]
        && (chan_irq_i & pmask) == 16'h0000) else $error("wrong port");
    a_type_word: assert property (s_win |-> io_data_o[14:11] == 4'h0
        && io_data_o[10:8] == chan_itype_i[prt]) else $error("wrong type");
    a_board_pick: assert property (s_win |-> !bpend_i[io_data_o[7:4]]
        && &(bpend_i | ~bmask)) else $error("wrong board answered");
    a_read_lat: assert property ($rose(io_data_oe) |->
        $past(io_rd_i, 4) && io_addr_i == msia_pkg::ARB_RESULT_ADDR)
        else $error("bad read");
    a_read_end: assert property ($fell(io_rd_i) |-> ##3 !io_data_oe)
        else $error("data bus held too long");
    a_rx_mark: assert property ((rx_open_i & $past(rx_open_i, 3)
        & ~chan_rxd_o) == 16'h0000) else $error("open receiver not mark");
    c_win: cover property (s_win);
    c_idle: cover property (io_data_oe && io_data_o[15]);
    c_irq: cover property (|irq_oe);
endmodule // msia_arbiter_chk
bind msia_arbiter msia_arbiter_chk u_chk (.clk_sys(clk_sys), .rst(rst),
    .io_rd_i(io_rd_i), .io_addr_i(io_addr_i), .io_data_o(io_data_o),
    .io_data_oe(io_data_oe), .irq_o(irq_o), .irq_oe(irq_oe),
    .bpend_i(bpend_i), .bpend_oe(bpend_oe), .chan_irq_i(chan_irq_i),
    .chan_itype_i(chan_itype_i), .rx_open_i(rx_open_i),
    .chan_rxd_o(chan_rxd_o));
`default_nettype wire

/* bench/msia_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// host side: setup writes and arbitration reads
module msia_host_model (
    // clock
    input wire logic clk_sys,
    // setup cycle
    output logic setup_wr,
    output msia_pkg::msia_setup_t setup_data,
    // i/o read
    output logic io_rd,
    output logic [15:0] io_addr,
    input wire logic [15:0] io_data,
    input wire logic io_data_oe
);
    // idle bus at time zero
    initial begin
        setup_wr = 1'b0;
        setup_data = msia_pkg::SETUP_RESET;
        io_rd = 1'b0;
        io_addr = 16'h0000;
    end
    // every board in the system gets the same line code from here
    task automatic setup(input logic en, input logic [2:0] s);
        @(negedge clk_sys);
        setup_wr = 1'b1;
        setup_data = '{enable: en, sel: msia_pkg::msia_irq_sel_t'(s)};
        @(negedge clk_sys);
        setup_wr = 1'b0;
    endtask
    // strobe and address held until the answer edge, 8 edges at most
    task automatic rd_word(input logic [15:0] a, output logic seen,
                           output logic [15:0] d);
        @(negedge clk_sys);
        io_addr = a;
        io_rd = 1'b1;
        seen = 1'b0;
        d = 16'h0000;
        for (int n = 0; n < 8 && !seen; n++) begin
            @(posedge clk_sys);
            seen = (io_data_oe === 1'b1);
            d = io_data;
        end
        @(negedge clk_sys);
        io_rd = 1'b0;
        io_addr = ~a; // stale address would hide a decode slip
        repeat (4) @(negedge clk_sys);
    endtask
endmodule // msia_host_model
`default_nettype wire

/* bench/tb_msia_arbiter.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// bench, this board strapped as board 2
module tb_msia_arbiter;
    typedef struct packed {
        logic [15:0] other;
        logic [15:0] irq;
        logic oe;
        logic [15:0] word;
    } msia_row_t;
    // other boards' pulls, our requests, expected answer
    msia_row_t rows [6] = '{'{16'h0000, 16'h0001, 1'b1, 16'h0020},
        '{16'h0000, 16'h8000, 1'b1, 16'h072F},
        '{16'h0008, 16'h00C0, 1'b1, 16'h0626},
        '{16'h0001, 16'h0001, 1'b0, 16'h0000},
        '{16'h0001, 16'h0000, 1'b0, 16'h0000},
        '{16'h0000, 16'h0000, 1'b1, 16'h8000}};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [15:0] other = 16'h0000, chan_irq = 16'h0000, txd = 16'hFFFF;
    logic [15:0] dtr = 16'h0000, rxd = 16'hFFFF, ropen = 16'h0000;
    logic [15:0] dcd = 16'h0000, word;
    logic [15:0][2:0] itype;
    logic seen, setup_wr, io_rd, io_data_oe;
    logic [15:0] io_addr, io_data, bpend_oe, chan_rxd, chan_dcd, txd_o, dtr_o;
    logic [15:0] bpend_o;
    logic idle_strap = 1'b1;
    logic [7:0] irq_oe;
    msia_pkg::msia_setup_t setup_data;
    int n_mismatch = 0;
    int samples_checked = 0;
    // open collector board lines with pull-ups
    wire logic [15:0] bpend_i = ~(bpend_oe | other);
    always #50 clk_sys = ~clk_sys;
    msia_host_model u_host (.clk_sys(clk_sys), .setup_wr(setup_wr),
        .setup_data(setup_data), .io_rd(io_rd), .io_addr(io_addr),
        .io_data(io_data), .io_data_oe(io_data_oe));
    msia_arbiter dut (.clk_sys(clk_sys), .rst(rst), .board_id_i(4'h2),
        .idle_resp_i(idle_strap), .setup_wr_i(setup_wr),
        .setup_data_i(setup_data),
        .io_rd_i(io_rd), .io_addr_i(io_addr), .io_data_o(io_data),
        .io_data_oe(io_data_oe), .irq_o(), .irq_oe(irq_oe),
        .bpend_i(bpend_i), .bpend_o(bpend_o), .bpend_oe(bpend_oe),
        .chan_irq_i(chan_irq), .chan_itype_i(itype), .chan_txd_i(txd),
        .chan_dtr_i(dtr), .chan_rxd_o(chan_rxd), .chan_dcd_o(chan_dcd),
        .txd_o(txd_o), .dtr_o(dtr_o), .rxd_i(rxd), .rx_open_i(ropen),
        .dcd_i(dcd));
    // one comparison of any port value
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ============================================================
    // main sequence
    initial begin
        for (int i = 0; i < 16; i++) begin
            itype[i] = 3'(i);
        end
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        chan_irq = 16'h0001;
        // each line code pulls exactly its own line
        for (int s = 0; s < 8; s++) begin
            u_host.setup(1'b1, 3'(s));
            repeat (3) @(negedge clk_sys);
            chk({8'h00, irq_oe}, 16'h1 << s);
            chk(bpend_oe, 16'h0004);
            chk(bpend_o, 16'h0000);
        end
        u_host.setup(1'b1, 3'h3);
        // table rows, read back to back
        foreach (rows[r]) begin
            other = rows[r].other;
            chan_irq = rows[r].irq;
            repeat (5) @(negedge clk_sys);
            chk({8'h00, irq_oe}, (|chan_irq) ? 16'h0008 : 16'h0000);
            chk(bpend_oe, (|chan_irq) ? 16'h0004 : 16'h0000);
            u_host.rd_word(16'h0130, seen, word);
            chk({15'h0, seen}, {15'h0, rows[r].oe});
            if (seen) begin
                chk(word, rows[r].word);
            end
        end
        // neighbour address must stay silent
        u_host.rd_word(16'h0132, seen, word);
        chk({15'h0, seen}, 16'h0000);
        // line levels, half the receivers left open
        txd = 16'hA5C3;
        dtr = 16'h00F0;
        rxd = 16'h0F0F;
        ropen = 16'h00FF;
        dcd = 16'h1234;
        repeat (4) @(negedge clk_sys);
        chk(txd_o, 16'hA5C3);
        chk(dtr_o, 16'h00F0);
        chk(chan_dcd, 16'h1234);
        chk(chan_rxd, 16'h0FFF);
        // second reset with a request pending: nothing driven after it
        chan_irq = 16'h0001;
        rst = 1'b1;
        idle_strap = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk(io_data, 16'h8000);
        chk({7'h00, io_data_oe, irq_oe}, 16'h0000);
        chk(txd_o, 16'hFFFF);
        chk(chan_rxd, 16'hFFFF);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk({8'h00, irq_oe}, 16'h0000);
        // idle strap now low: nothing pending and nobody answers
        u_host.rd_word(16'h0130, seen, word);
        chk({15'h0, seen}, 16'h0000);
        end_sim();
    end
endmodule // tb_msia_arbiter
`default_nettype wire
